// ===== rtl/pss_pkg.sv
package pss_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam int          NUM_WORDS      = 6;
  localparam int          WORD_W         = 11;
  localparam logic [7:0]  ADR_WORD0      = 8'h00;
  localparam logic [7:0]  ADR_WORD1      = 8'h04;
  localparam logic [7:0]  ADR_WORD2      = 8'h08;
  localparam logic [7:0]  ADR_WORD3      = 8'h0c;
  localparam logic [7:0]  ADR_WORD4      = 8'h10;
  localparam logic [7:0]  ADR_FACTORY    = 8'h14;  // factory_test_config_word
  localparam logic [7:0]  ADR_READBACK   = 8'h18;
  localparam logic [7:0]  ADR_STATUS     = 8'h1c;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int          SEL_LSB        = 0;   // word_select_bit0..2
  localparam int          SEL_MSB        = 2;
  localparam int          FIXED_BIT      = 10;  // startup fixed one / zero bit
  localparam int          VCO_SEL_BIT    = 3;
  localparam int          PRESC_LSB      = 4;
  localparam int          PRESC_MSB      = 5;
  localparam int          OUTDIV_LSB     = 6;
  localparam int          OUTDIV_MSB     = 8;
  localparam int          CALWORD_LSB    = 3;
  localparam int          CALWORD_MSB    = 8;
  localparam int          CALOVR_BIT     = 9;
  localparam int          FACTORY_LSB    = 3;   // factory_test_field
  localparam int          FACTORY_MSB    = 6;
  localparam int          REV_LSB        = 0;
  localparam int          REV_MSB        = 2;

  // reset values equal the recommended programming of each word
  localparam logic [WORD_W-1:0] WORD_RESET [NUM_WORDS] = '{
    11'h400, 11'h2f9, 11'h01a, 11'h3c3, 11'h404, 11'h005
  };

  // product revision code: value is arbitrary
  localparam logic [2:0]  REV_ID_DEFAULT = 3'h5;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 40;
  localparam int          STAB_REF_PER   = 16384;
  localparam int          CAL_REF_PER    = 550;
  localparam int          LOCK_TIME_NS   = 12500;
  localparam int          LOCK_CYCLES    = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W          = 15;

  // ---------------------------------------------------------------
  // startup states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PSS_OSC_WAIT = 3'b000,
    PSS_STAB     = 3'b001,
    PSS_CAL      = 3'b010,
    PSS_LOCK     = 3'b011,
    PSS_DONE     = 3'b100
  } pss_state_t;

  typedef struct packed {
    logic [17:0] rsvd;
    logic [5:0]  vco_trim;
    logic [2:0]  pad;
    logic        done;
    logic        osc_ok;
    logic [2:0]  state;
  } pss_status_t;

endpackage : pss_pkg

// ===== rtl/pss_top.sv
// Added by the designer: the placing of the registers and register access over Wishbone.
module pss_top
  import pss_pkg::*;
#(
  parameter int          STAB_CYCLES = STAB_REF_PER,
  parameter logic [2:0]  REV_ID      = REV_ID_DEFAULT
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        osc_valid_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             osc_en_o,
  output logic             cal_active_o,
  output logic             startup_done_o,
  output logic             vco_sel_o,
  output logic [5:0]       vco_trim_o
);

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  pss_state_t        state_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              osc_en_q;
  logic              osc_meta_q;
  logic              osc_ok_q;
  logic              ack_q;
  logic [31:0]       rdat_q;
  logic [5:0]        trim_q;
  logic [WORD_W-1:0] cfg_q [NUM_WORDS];
  logic              req;
  logic              wr_stb;
  logic              stab_last;
  logic              cal_last;
  logic              lock_last;
  logic [2:0]        word_idx;
  logic              word_hit;
  pss_status_t       status;

  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------
  // write lands on the edge at which the master sees ack
  assign req      = wb_cyc_i & wb_stb_i;
  assign wr_stb   = req & wb_we_i & ack_q;
  assign word_idx = wb_adr_i[4:2];
  assign word_hit = (wb_adr_i[7:5] == 3'h0) && (wb_adr_i[1:0] == 2'h0)
                    && (word_idx < 3'(NUM_WORDS));

  // -----------------------------------------------------------------
  // configuration words
  // -----------------------------------------------------------------
  // selection bits are fixed per word, so a stray write cannot remap a word
  for (genvar w = 0; w < NUM_WORDS; w++) begin : g_word
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        cfg_q[w] <= WORD_RESET[w];
      else if (wr_stb && word_hit && (word_idx == 3'(w)))
      begin
        if (wb_sel_i[0])
          cfg_q[w][7:3] <= wb_dat_i[7:3];
        if (wb_sel_i[1])
          cfg_q[w][10:8] <= wb_dat_i[10:8];
      end
    end
  end

  // -----------------------------------------------------------------
  // bus answer
  // -----------------------------------------------------------------
  // one wait state; unmapped offsets still ack with zero data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= req & ~ack_q;
  end

  always_comb
  begin
    status          = '0;
    status.state    = state_q;
    status.osc_ok   = osc_ok_q;
    status.done     = (state_q == PSS_DONE);
    status.vco_trim = trim_q;
  end

  // read data registered on the request edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdat_q <= '0;
    else if (req && !ack_q)
    begin
      if (word_hit)
        rdat_q <= {21'h0, cfg_q[word_idx]};
      else if (wb_adr_i == ADR_READBACK)
        rdat_q <= {29'h0, REV_ID};
      else if (wb_adr_i == ADR_STATUS)
        rdat_q <= status;
      else
        rdat_q <= '0;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // -----------------------------------------------------------------
  // oscillator enable and valid synchroniser
  // -----------------------------------------------------------------
  // held low through reset, set on the first edge after release
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      osc_en_q <= 1'b0;
    else
      osc_en_q <= 1'b1;
  end

  // valid level comes from the analog side, two flops before use
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      osc_meta_q <= 1'b0;
      osc_ok_q   <= 1'b0;
    end
    else
    begin
      osc_meta_q <= osc_valid_i;
      osc_ok_q   <= osc_meta_q;
    end
  end

  assign osc_en_o = osc_en_q;

  // -----------------------------------------------------------------
  // startup sequencer
  // -----------------------------------------------------------------
  assign stab_last = (cnt_q == CNT_W'(STAB_CYCLES - 1));
  assign cal_last  = (cnt_q == CNT_W'(CAL_REF_PER - 1));
  assign lock_last = (cnt_q == CNT_W'(LOCK_CYCLES - 1));

  // clk_i is the reference clock itself, so every count is in periods
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= PSS_OSC_WAIT;
      cnt_q   <= '0;
    end
    else
    begin
      unique case (state_q)
        PSS_OSC_WAIT:
        begin
          cnt_q <= '0;
          if (osc_en_q && osc_ok_q)
          begin
            state_q <= PSS_STAB;
          end
        end
        PSS_STAB:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (stab_last)
          begin
            state_q <= PSS_CAL;
            cnt_q   <= '0;
          end
        end
        PSS_CAL:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cal_last)
          begin
            state_q <= PSS_LOCK;
            cnt_q   <= '0;
          end
        end
        PSS_LOCK:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (lock_last)
          begin
            state_q <= PSS_DONE;
            cnt_q   <= '0;
          end
        end
        PSS_DONE:
        begin
          cnt_q <= '0;
        end
        default:
        begin
          state_q <= PSS_OSC_WAIT;
          cnt_q   <= '0;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // VCO operating point
  // -----------------------------------------------------------------
  // latched at the end of calibration from the PLL settings, or from the word 4 cal word when its override bit is set, then held;
  // later writes never reach it, since the reset that restarts the sequence also reloads every word
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      trim_q <= '0;
    else if (state_q == PSS_CAL && cal_last)
    begin
      if (cfg_q[4][CALOVR_BIT])
        trim_q <= cfg_q[4][CALWORD_MSB:CALWORD_LSB];
      else
        trim_q <= {cfg_q[0][OUTDIV_MSB:OUTDIV_LSB],
                   cfg_q[0][PRESC_MSB:PRESC_LSB],
                   cfg_q[0][VCO_SEL_BIT]};
    end
  end

  assign vco_trim_o     = trim_q;
  assign vco_sel_o      = cfg_q[0][VCO_SEL_BIT];
  assign cal_active_o   = (state_q == PSS_CAL);
  assign startup_done_o = (state_q == PSS_DONE);

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  // helper: cycles spent in the current state
  logic [CNT_W-1:0] dwell_q;
  pss_state_t       prev_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dwell_q <= '0;
      prev_q  <= PSS_OSC_WAIT;
    end
    else
    begin
      prev_q  <= state_q;
      dwell_q <= (prev_q == state_q) ? dwell_q + 1'b1 : '0;
    end
  end

  property p_osc_off_in_reset;
    @(posedge clk_i) rst_i |=> !osc_en_o ##1 ($past(rst_i) || osc_en_o);
  endproperty
  a_osc_off_in_reset: assert property (p_osc_off_in_reset)
    else $error("oscillator enable wrong around reset");

  property p_wait_for_osc;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == PSS_OSC_WAIT && !osc_ok_q) |=> state_q == PSS_OSC_WAIT;
  endproperty
  a_wait_for_osc: assert property (p_wait_for_osc)
    else $error("delay started before oscillator valid");

  property p_stab_len;
    @(posedge clk_i) disable iff (rst_i)
      (prev_q == PSS_STAB && state_q == PSS_CAL)
        |-> dwell_q == CNT_W'(STAB_CYCLES - 1);
  endproperty
  a_stab_len: assert property (p_stab_len)
    else $error("stabilisation wait has wrong length");

  property p_cal_len;
    @(posedge clk_i) disable iff (rst_i)
      (prev_q == PSS_CAL && state_q == PSS_LOCK)
        |-> dwell_q == CNT_W'(CAL_REF_PER - 1);
  endproperty
  a_cal_len: assert property (p_cal_len)
    else $error("calibration has wrong length");

  property p_cal_follows_stab;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == PSS_STAB && stab_last) |=> cal_active_o [*8];
  endproperty
  a_cal_follows_stab: assert property (p_cal_follows_stab)
    else $error("calibration did not follow stabilisation");

  property p_lock_len;
    @(posedge clk_i) disable iff (rst_i)
      $rose(startup_done_o) |-> prev_q == PSS_LOCK
        && dwell_q == CNT_W'(LOCK_CYCLES - 1);
  endproperty
  a_lock_len: assert property (p_lock_len)
    else $error("lock wait has wrong length");

  property p_done_auto;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == PSS_LOCK && lock_last) |=> startup_done_o ##1 startup_done_o;
  endproperty
  a_done_auto: assert property (p_done_auto)
    else $error("startup did not complete on its own");

  property p_restart;
    @(posedge clk_i) rst_i |=> state_q == PSS_OSC_WAIT && !startup_done_o
      && !cal_active_o;
  endproperty
  a_restart: assert property (p_restart)
    else $error("reset did not restart the sequence");

  property p_rev_id;
    @(posedge clk_i) disable iff (rst_i)
      (wb_ack_o && !wb_we_i && wb_adr_i == ADR_READBACK)
        |-> wb_dat_o[REV_MSB:REV_LSB] == REV_ID && wb_dat_o[31:3] == '0;
  endproperty
  a_rev_id: assert property (p_rev_id)
    else $error("revision code wrong in readback");

endmodule : pss_top

// ===== tb/pss_osc_model.sv
module pss_osc_model #(
  parameter int START_CYC = 30
)(
  input  wire logic clk_i,
  input  wire logic osc_en_i,
  output logic      osc_valid_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // oscillator startup
  // ---------------------------------------------------------------
  int cnt_q = 0;

  // levels turn valid only after a startup time; lost at once when disabled
  always @(posedge clk_i)
  begin
    if (osc_en_i !== 1'b1)
    begin
      cnt_q       <= 0;
      osc_valid_o <= 1'b0;
    end
    else if (cnt_q < START_CYC)
      cnt_q <= cnt_q + 1;
    else
      osc_valid_o <= 1'b1;
  end

endmodule : pss_osc_model

// ===== tb/testbench.sv
module testbench
  import pss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // setup
  // ---------------------------------------------------------------
  localparam int         STAB  = 20;
  localparam logic [2:0] REV   = 3'h2;  // arbitrary revision code
  localparam int         LIMIT = 5000;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        osc_en;
  logic        osc_valid;
  logic        cal;
  logic        done;
  logic        vsel;
  logic [5:0]  trim;
  int          mismatches = 0;
  int          n_tests    = 0;
  int          cycles     = 0;

  always #20 clk_i = ~clk_i;

  pss_top #(.STAB_CYCLES(STAB), .REV_ID(REV)) u_pss_top (
    .clk_i(clk_i), .rst_i(rst_i), .osc_valid_i(osc_valid), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .osc_en_o(osc_en),
    .cal_active_o(cal), .startup_done_o(done), .vco_sel_o(vsel),
    .vco_trim_o(trim));

  pss_osc_model u_pss_osc_model (
    .clk_i(clk_i), .osc_en_i(osc_en), .osc_valid_o(osc_valid));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : check

  // one classic cycle; waits on ack, no latency assumed
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'h3;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : bus

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(string n, logic [7:0] a, logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(n, q, e);
  endtask : rd_chk

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic do_reset(int n);
    rst_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    check("osc_en in reset", osc_en, 32'h0);
    check("cal in reset", cal, 32'h0);
    check("done in reset", done, 32'h0);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("osc_en after reset", osc_en, 32'h1);
  endtask : do_reset

  // measures every step of the startup from the oscillator going valid
  task automatic startup(logic [5:0] t_exp, logic v_exp);
    int n;
    n = 0;
    while (osc_valid !== 1'b1) @(posedge clk_i);
    while (cal !== 1'b1)
    begin
      @(posedge clk_i);
      n++;
    end
    // two sync flops plus the step out of the wait state
    check("stab delay", n, STAB + 3);
    n = 0;
    while (cal === 1'b1)
    begin
      @(posedge clk_i);
      n++;
    end
    check("cal length", n, CAL_REF_PER);
    n = 0;
    while (done !== 1'b1)
    begin
      @(posedge clk_i);
      n++;
    end
    check("lock wait", n, LOCK_CYCLES);
    check("trim", trim, t_exp);
    check("vco sel", vsel, v_exp);
  endtask : startup

  task automatic t_regs;
    for (int i = 0; i < NUM_WORDS; i++)
      rd_chk("word reset", ADR_WORD0 + 8'(4 * i), 32'(WORD_RESET[i]));
    rd_chk("revision", ADR_READBACK, {29'h0, REV});
    wr(ADR_READBACK, 32'h7);
    rd_chk("revision kept", ADR_READBACK, {29'h0, REV});
    rd_chk("unmapped", 8'h20, 32'h0);
    wr(ADR_WORD0, 32'h568);
    wr(ADR_WORD3, 32'h3c3);
    rd_chk("word0", ADR_WORD0, 32'h568);
  endtask : t_regs

  // reset in mid-calibration restarts from the oscillator enable
  task automatic t_abort;
    do_reset(2);
    while (cal !== 1'b1) @(posedge clk_i);
    repeat (100) @(posedge clk_i);
    do_reset(2);
    // override trim written while the fresh startup still waits for the oscillator
    fork
      wr(ADR_WORD4, 32'h6ac);
      startup(6'h15, 1'b0);
    join
  endtask : t_abort

  // hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      finish_test;
    end
  end

  initial
  begin
    do_reset(16);
    // register traffic runs while startup is measured from the valid edge
    fork
      t_regs;
      startup(6'h2d, 1'b1);
    join
    rd_chk("status", ADR_STATUS, {18'h0, 6'h2d, 3'h0, 1'b1, 1'b1, 3'h4});
    t_abort;
    finish_test;
  end

endmodule : testbench
